// ==== core/ppt_pkg.sv ====
// ppt_pkg: constants and carrier types for the pulse-per-second time-tag block.
// assumes a single 40 mhz core clock and bcd-coded utc time from the gps reference.
`default_nettype none

package ppt_pkg;

  // clock and timing, figures in their own units
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned PULSE_US      = 1000;       // 1 ms pulse width
  localparam int unsigned LEAD_MS       = 500;        // message 0.5 s ahead of pulse
  localparam int unsigned PULSE_CYC     = (CLK_HZ / 1_000_000) * PULSE_US;
  localparam int unsigned LEAD_CYC      = (CLK_HZ / 1000) * LEAD_MS;

  // message layout, character index of each landmark
  localparam logic [4:0]  IDX_FIRST_SUM = 5'h01;      // first char after dollar
  localparam logic [4:0]  IDX_LAST_SUM  = 5'h1a;      // last year digit
  localparam logic [4:0]  IDX_LAST      = 5'h1f;      // line feed

  // ascii characters
  localparam logic [7:0]  CH_DOLLAR     = 8'h24;
  localparam logic [7:0]  CH_COMMA      = 8'h2c;
  localparam logic [7:0]  CH_DOT        = 8'h2e;
  localparam logic [7:0]  CH_STAR       = 8'h2a;
  localparam logic [7:0]  CH_CR         = 8'h0d;
  localparam logic [7:0]  CH_LF         = 8'h0a;
  localparam logic [7:0]  CH_ZERO       = 8'h30;
  localparam logic [7:0]  CH_A_MINUS_10 = 8'h37;      // 'A' - 10
  localparam logic [7:0]  CH_I          = 8'h49;
  localparam logic [7:0]  CH_N          = 8'h4e;
  localparam logic [7:0]  CH_Z          = 8'h5a;
  localparam logic [7:0]  CH_D          = 8'h44;
  localparam logic [7:0]  CH_A          = 8'h41;

  // fractional seconds in the tag: sent half a second after the boundary
  localparam logic [7:0]  FRAC_BCD      = 8'h50;

  // bcd utc time of the current gps second
  typedef struct packed {
    logic [15:0] year;
    logic [7:0]  month;
    logic [7:0]  day;
    logic [7:0]  hour;
    logic [7:0]  minute;
    logic [7:0]  second;
  } ppt_time_t;

  // setup selections
  typedef struct packed {
    logic        pps_on_radar;   // pulse chosen as clock data format
    logic [1:0]  tag_on_output;  // time-tag format chosen per data output
  } ppt_cfg_t;

  typedef enum logic {PPT_IDLE, PPT_SEND} ppt_state_t;

endpackage

`default_nettype wire

// ==== core/ppt_top.sv ====
// ppt_top: one pulse per second on the radar terminal and a once-per-second
// ascii time-tag message on up to two character outputs.
// assumes gps_sec_tick is a one-cycle pulse on each gps second boundary and
// that gps_time holds the utc time of that boundary from the tick onward.
`timescale 1ns/100ps
`default_nettype none

// Contract
// - pulse output is active high and lasts 1 ms, then returns low.
// - exactly one pulse per second, rising edge on the gps second boundary.
// - pulse reaches the radar terminal pin only when setup selects it.
// - time-tag message sent each second, half a second before the next pulse.
// - message carries utc time of sending; next pulse marks the next whole second.
// - order: dollar, identifier, time, day, month, year, star, checksum, terminator.
// - time as hhmmss.ss within 00-23, 00-59, 00.00-59.99.
// - day of month as two digits 01 to 31.
// - month as two digits 01 to 12.
// - year as four decimal digits.
// - checksum is xor of characters between dollar and star, sent in hex.
// - message ends with carriage return then line feed.
// - each of the two data outputs selects the time-tag format on its own.
module ppt_top #(
  parameter int unsigned PULSE_CYCLES = ppt_pkg::PULSE_CYC,
  parameter int unsigned LEAD_CYCLES  = ppt_pkg::LEAD_CYC
) (
  input  wire logic              core_clk,
  input  wire logic              srst,
  input  wire logic              gps_sec_tick,
  input  wire ppt_pkg::ppt_time_t gps_time,
  input  wire ppt_pkg::ppt_cfg_t  setup_cfg,
  input  wire logic [1:0]        tag_ready,
  output var  logic              radar_terminal_signal_pin,
  output var  logic [1:0]        tag_valid,
  output var  logic [7:0]        tag_char
);
  import ppt_pkg::*;

  // one bcd nibble to its ascii digit
  function automatic logic [7:0] dig(input logic [3:0] n);
    dig = CH_ZERO | {4'h0, n};
  endfunction

  // one nibble to an upper-case hex character
  function automatic logic [7:0] hexc(input logic [3:0] n);
    if (n > 4'h9) begin
      hexc = CH_A_MINUS_10 + {4'h0, n};
    end else begin
      hexc = CH_ZERO + {4'h0, n};
    end
  endfunction

  // character at a given message position:
  // 00 dollar, 01-05 talker and sentence, 06 comma
  // 07-0f time, 10-12 day
  // 13-15 month, 16-1a year
  // 1b star, 1c-1d checksum, 1e-1f cr lf
  function automatic logic [7:0] char_at(input logic [4:0] i,
                                         input ppt_time_t t,
                                         input logic [7:0] cs);
    case (i)
      5'h00:   char_at = CH_DOLLAR;
      5'h01:   char_at = CH_I;
      5'h02:   char_at = CH_N;
      5'h03:   char_at = CH_Z;
      5'h04:   char_at = CH_D;
      5'h05:   char_at = CH_A;
      5'h06:   char_at = CH_COMMA;
      5'h07:   char_at = dig(t.hour[7:4]);
      5'h08:   char_at = dig(t.hour[3:0]);
      5'h09:   char_at = dig(t.minute[7:4]);
      5'h0a:   char_at = dig(t.minute[3:0]);
      5'h0b:   char_at = dig(t.second[7:4]);
      5'h0c:   char_at = dig(t.second[3:0]);
      5'h0d:   char_at = CH_DOT;
      5'h0e:   char_at = dig(FRAC_BCD[7:4]);
      5'h0f:   char_at = dig(FRAC_BCD[3:0]);
      5'h10:   char_at = CH_COMMA;
      5'h11:   char_at = dig(t.day[7:4]);
      5'h12:   char_at = dig(t.day[3:0]);
      5'h13:   char_at = CH_COMMA;
      5'h14:   char_at = dig(t.month[7:4]);
      5'h15:   char_at = dig(t.month[3:0]);
      5'h16:   char_at = CH_COMMA;
      5'h17:   char_at = dig(t.year[15:12]);
      5'h18:   char_at = dig(t.year[11:8]);
      5'h19:   char_at = dig(t.year[7:4]);
      5'h1a:   char_at = dig(t.year[3:0]);
      5'h1b:   char_at = CH_STAR;
      5'h1c:   char_at = hexc(cs[7:4]);
      5'h1d:   char_at = hexc(cs[3:0]);
      5'h1e:   char_at = CH_CR;
      default: char_at = CH_LF;
    endcase
  endfunction

  // pulse timing state
  logic [31:0]  pulse_cnt_q;
  logic [31:0]  pulse_cnt_d;
  logic         pulse_q;
  logic         pulse_d;
  logic         pin_q;
  logic         pin_d;

  // second-phase state: counts from the boundary toward the message start
  logic [31:0]  lead_cnt_q;
  logic [31:0]  lead_cnt_d;
  logic         lead_run_q;
  logic         lead_run_d;
  ppt_time_t    sec_time_q;
  ppt_time_t    sec_time_d;

  // message sender state
  ppt_state_t   state_q;
  ppt_state_t   state_d;
  ppt_time_t    msg_time_q;
  ppt_time_t    msg_time_d;
  logic [4:0]   idx_q;
  logic [4:0]   idx_d;
  logic [7:0]   csum_q;
  logic [7:0]   csum_d;
  logic [1:0]   sel_q;
  logic [1:0]   sel_d;
  logic [1:0]   valid_q;
  logic [1:0]   valid_d;
  logic [7:0]   char_q;
  logic [7:0]   char_d;

  // decode wires
  wire logic        pulse_start;
  wire logic        pulse_end;
  wire logic        any_tag;
  wire logic        lead_hit;
  wire logic [1:0]  pend;
  wire logic        slot_free;
  wire logic        start_msg;
  wire logic [4:0]  idx_next;
  wire logic [7:0]  char_next;
  wire logic [7:0]  char_first;
  wire logic        in_sum;

  // pulse: a tick raises the line, the counter drops it after the width;
  // a tick inside a pulse is ignored so a glitchy reference cannot double it
  assign pulse_start = gps_sec_tick && !pulse_q;
  assign pulse_end   = pulse_q && (pulse_cnt_q == 32'(PULSE_CYCLES - 1));
  assign pulse_d     = pulse_start ? 1'b1 :
                       (pulse_end ? 1'b0 : pulse_q);
  assign pulse_cnt_d = pulse_start ? 32'h0 :
                       (pulse_q ? pulse_cnt_q + 32'h1 : 32'h0);
  // edge of the pin lines up with the tick: drive it from the same decision
  assign pin_d       = setup_cfg.pps_on_radar && pulse_d;

  // lead counter: restarted on every boundary, fires half a second later
  assign lead_hit    = lead_run_q && (lead_cnt_q == 32'(LEAD_CYCLES - 1));
  assign lead_run_d  = gps_sec_tick ? 1'b1 : (lead_hit ? 1'b0 : lead_run_q);
  assign lead_cnt_d  = gps_sec_tick ? 32'h0 :
                       (lead_run_q ? lead_cnt_q + 32'h1 : 32'h0);
  // the time of the boundary just passed; next pulse is that plus one second
  assign sec_time_d  = gps_sec_tick ? gps_time : sec_time_q;

  // a message only goes out if some output has the time-tag format chosen;
  // a message still draining from a slow output makes the next one skip
  assign any_tag     = (setup_cfg.tag_on_output != 2'h0);
  assign start_msg   = lead_hit && (state_q == PPT_IDLE) &&
                       any_tag;

  // character handover: each output drops its valid bit when it accepts,
  // the next character loads once every selected output has taken this one
  for (genvar g = 0; g < 2; g++) begin : g_pend
    assign pend[g] = valid_q[g] && !tag_ready[g];
  end
  assign slot_free   = (pend == 2'h0);
  assign idx_next    = idx_q + 5'h1;
  assign char_first  = char_at(5'h00, sec_time_q, 8'h00);
  assign char_next   = char_at(idx_next, msg_time_q, csum_q);
  assign in_sum      = (idx_next >= IDX_FIRST_SUM) && (idx_next <= IDX_LAST_SUM);

  // sender next state
  always_comb begin
    state_d    = state_q;
    msg_time_d = msg_time_q;
    idx_d      = idx_q;
    csum_d     = csum_q;
    sel_d      = sel_q;
    valid_d    = pend;
    char_d     = char_q;
    case (state_q)
      PPT_IDLE: begin
        valid_d = 2'h0;
        if (start_msg) begin
          state_d    = PPT_SEND;
          msg_time_d = sec_time_q;
          idx_d      = 5'h00;
          csum_d     = 8'h00;
          sel_d      = setup_cfg.tag_on_output;
          valid_d    = setup_cfg.tag_on_output;
          char_d     = char_first;
        end
      end
      PPT_SEND: begin
        if (slot_free) begin
          if (idx_q == IDX_LAST) begin
            // line feed accepted: message complete
            state_d = PPT_IDLE;
            valid_d = 2'h0;
          end else begin
            idx_d   = idx_next;
            char_d  = char_next;
            valid_d = sel_q;
            if (in_sum) begin
              csum_d = csum_q ^ char_next;
            end
          end
        end
      end
      default: begin
        state_d = PPT_IDLE;
        valid_d = 2'h0;
      end
    endcase
  end

  // pulse width counter
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pulse_q     <= 1'b0;
      pulse_cnt_q <= 32'h0;
    end else begin
      pulse_q     <= pulse_d;
      pulse_cnt_q <= pulse_cnt_d;
    end
  end

  // pin flop, kept apart so the output stays a bare register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= pin_d;
    end
  end

  // lead counter toward the message start
  always_ff @(posedge core_clk) begin
    if (srst) begin
      lead_run_q <= 1'b0;
      lead_cnt_q <= 32'h0;
    end else begin
      lead_run_q <= lead_run_d;
      lead_cnt_q <= lead_cnt_d;
    end
  end

  // time of the last boundary
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sec_time_q <= '0;
    end else begin
      sec_time_q <= sec_time_d;
    end
  end

  // sender control
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_q <= PPT_IDLE;
      idx_q   <= 5'h00;
      sel_q   <= 2'h0;
    end else begin
      state_q <= state_d;
      idx_q   <= idx_d;
      sel_q   <= sel_d;
    end
  end

  // stream outputs; reset clears them so nothing looks valid early
  always_ff @(posedge core_clk) begin
    if (srst) begin
      valid_q <= 2'h0;
      char_q  <= 8'h00;
    end else begin
      valid_q <= valid_d;
      char_q  <= char_d;
    end
  end

  // message time and running checksum
  always_ff @(posedge core_clk) begin
    if (srst) begin
      msg_time_q <= '0;
      csum_q     <= 8'h00;
    end else begin
      msg_time_q <= msg_time_d;
      csum_q     <= csum_d;
    end
  end

  // outputs straight from flops
  assign radar_terminal_signal_pin = pin_q;
  assign tag_valid                 = valid_q;
  assign tag_char                  = char_q;

endmodule // ppt_top

`default_nettype wire

// ==== testbench/ppt_top_chk.sv ====
// ppt_chk: timing checks on the pulse line and the tag character stream.
// assumes the setup stays still while a pulse or a message is under way.
`timescale 1ns/100ps
`default_nettype none
module ppt_chk #(
  parameter int unsigned PULSE_CYCLES = 10,
  parameter int unsigned LEAD_CYCLES  = 100
) (
  input wire logic              core_clk,
  input wire logic              srst,
  input wire logic              gps_sec_tick,
  input wire ppt_pkg::ppt_cfg_t setup_cfg,
  input wire logic [1:0]        tag_ready,
  input wire logic              radar_terminal_signal_pin,
  input wire logic [1:0]        tag_valid,
  input wire logic [7:0]        tag_char
);
  import ppt_pkg::*;
  logic [31:0] since_q;  // cycles since the last tick
  logic [31:0] high_q;   // cycles the pin has been high
  // counters instead of long repetitions, which the tools cannot unroll
  always_ff @(posedge core_clk) begin
    since_q <= (srst || gps_sec_tick) ? 32'h0 : since_q + 32'h1;
    high_q  <= radar_terminal_signal_pin ? high_q + 32'h1 : 32'h0;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  sequence s_rise; $rose(radar_terminal_signal_pin); endsequence
  sequence s_start; $rose(|tag_valid); endsequence
  // pulse and message timing against the tick, pin gating, message framing and character handover
  a_pulse_on_tick: assert property (s_rise |-> since_q == 32'h0)
    else $error("pulse rose away from a tick");
  a_pulse_width: assert property ($fell(radar_terminal_signal_pin) |-> high_q == PULSE_CYCLES)
    else $error("pulse width wrong");
  a_pin_gated: assert property (!setup_cfg.pps_on_radar |=> !radar_terminal_signal_pin)
    else $error("pulse seen while not selected");
  a_lead_time: assert property (s_start |-> since_q == LEAD_CYCLES)
    else $error("message start not at lead time");
  a_first_dollar: assert property (s_start |-> tag_char == CH_DOLLAR)
    else $error("message does not open with dollar");
  a_output_select: assert property (s_start |-> tag_valid == $past(setup_cfg.tag_on_output))
    else $error("valid does not follow output selection");
  a_char_held: assert property (|(tag_valid & ~tag_ready) |=> $stable(tag_char)
    && (($past(tag_valid & ~tag_ready) & ~tag_valid) == 2'b00))
    else $error("character dropped before acceptance");
  a_ends_lf: assert property ($fell(|tag_valid) |-> $past(tag_char) == CH_LF)
    else $error("message does not end in line feed");
endmodule // ppt_chk
bind ppt_top ppt_chk #(.PULSE_CYCLES(PULSE_CYCLES), .LEAD_CYCLES(LEAD_CYCLES)) chk_u (
  .core_clk, .srst, .gps_sec_tick, .setup_cfg, .tag_ready, .radar_terminal_signal_pin,
  .tag_valid, .tag_char);
`default_nettype wire

// ==== testbench/ppt_sink.sv ====
// ppt_sink: far-side character receiver for one data output.
// assumes the block takes a character on an edge with valid and ready high.
`timescale 1ns/100ps
`default_nettype none
module ppt_sink (
  input  wire logic       core_clk,
  input  wire logic       srst,
  input  wire logic       stall,
  input  wire logic       tag_valid,
  input  wire logic [7:0] tag_char,
  output var  logic       tag_ready
);
  logic [7:0] got[$];   // characters taken so far
  logic [4:0] lfsr_q;   // stall pattern, changes every cycle
  initial begin
    tag_ready = 1'b0;
    lfsr_q = 5'h13;
  end
  // take on the edge, then move ready just after it
  always @(posedge core_clk) begin
    if (tag_valid && tag_ready) got.push_back(tag_char);
    lfsr_q <= {lfsr_q[3:0], lfsr_q[4] ^ lfsr_q[2]};
    tag_ready <= #1 !srst && (!stall || lfsr_q[0]);
  end
endmodule // ppt_sink
`default_nettype wire

// ==== testbench/tb.sv ====
// tb: drives ticks, time and setup into ppt_top with shortened counts and
// checks pulse timing and both tag streams against the expected text.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import ppt_pkg::*;
  localparam int unsigned PC = 10;
  localparam int unsigned LC = 100;
  logic       core_clk = 1'b0, srst = 1'b1, gps_sec_tick = 1'b0;
  ppt_time_t  gps_time = '0;
  ppt_cfg_t   setup_cfg = '0;
  wire  [1:0] tag_ready;
  logic [1:0] tag_valid, stall = 2'b00;
  logic       radar_terminal_signal_pin;
  logic [7:0] tag_char;
  logic [7:0] exp_s[$];
  int         seed = 32'h162f, bad_count = 0, comparisons = 0;
  always #12.5 core_clk = ~core_clk;
  ppt_top #(.PULSE_CYCLES(PC), .LEAD_CYCLES(LC)) dut_u (.core_clk, .srst, .gps_sec_tick,
    .gps_time, .setup_cfg, .tag_ready, .radar_terminal_signal_pin, .tag_valid, .tag_char);
  ppt_sink rx0_u (.core_clk, .srst, .stall(stall[0]), .tag_valid(tag_valid[0]), .tag_char,
    .tag_ready(tag_ready[0]));
  ppt_sink rx1_u (.core_clk, .srst, .stall(stall[1]), .tag_valid(tag_valid[1]), .tag_char,
    .tag_ready(tag_ready[1]));
  function int rnd(input int n);
    return ($random(seed) & 32'h7fffffff) % n;
  endfunction
  function automatic logic [7:0] bcd(input int v);
    return {4'(v / 10), 4'(v % 10)};
  endfunction
  // expected sentence: dollar, body, star, checksum, cr, lf
  function automatic void build(input ppt_time_t t);
    string s;
    string hexd = "0123456789ABCDEF";
    logic [7:0] cs;
    s = $sformatf("INZDA,%h%h%h.50,%h,%h,%h", t.hour, t.minute, t.second, t.day, t.month,
      t.year);
    cs = 8'h00;
    exp_s = {CH_DOLLAR};
    foreach (s[i]) begin
      cs = cs ^ s[i];
      exp_s.push_back(s[i]);
    end
    exp_s = {exp_s, CH_STAR, hexd[cs[7:4]], hexd[cs[3:0]], CH_CR, CH_LF};
  endfunction
  task automatic cmp_n(input int got, input int exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL t=%0t count got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_c(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL t=%0t char got %h exp %h", $time, got, exp);
    end
  endtask
  // one gps second: tick, watch the pin, then compare both received streams
  task automatic run_sec(input ppt_cfg_t c, input ppt_time_t t, input logic dbl);
    int rose_at, hi;
    rose_at = -1;
    hi = 0;
    build(t);
    rx0_u.got.delete();
    rx1_u.got.delete();
    setup_cfg = c;
    gps_time = t;
    gps_sec_tick = 1'b1;
    @(posedge core_clk);
    #1 gps_sec_tick = 1'b0;
    for (int i = 0; i < 300; i++) begin
      if (dbl && i == 3) gps_sec_tick = 1'b1;  // stray tick inside the pulse
      if (dbl && i == 4) gps_sec_tick = 1'b0;
      if (radar_terminal_signal_pin === 1'b1) begin
        hi++;
        if (rose_at < 0) rose_at = i;
      end
      @(posedge core_clk);
      #1;
    end
    cmp_n(hi, c.pps_on_radar ? PC : 0);
    if (c.pps_on_radar) cmp_n(rose_at, 0);
    cmp_n(rx0_u.got.size(), c.tag_on_output[0] ? 32 : 0);
    cmp_n(rx1_u.got.size(), c.tag_on_output[1] ? 32 : 0);
    for (int i = 0; i < 32; i++) begin
      if (c.tag_on_output[0]) cmp_c(rx0_u.got[i], exp_s[i]);
      if (c.tag_on_output[1]) cmp_c(rx1_u.got[i], exp_s[i]);
    end
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // every setup code once, then random; first two seconds are calendar corners
  initial begin
    ppt_time_t t;
    ppt_cfg_t c;
    repeat (3) @(posedge core_clk);
    #1 srst = 1'b0;
    for (int k = 0; k < 12; k++) begin
      c = (k < 8) ? 3'(k) : 3'(rnd(8));
      t = {bcd(19 + rnd(2)), bcd(rnd(100)), bcd(1 + rnd(12)), bcd(1 + rnd(31)),
        bcd(rnd(24)), bcd(rnd(60)), bcd(rnd(60))};
      if (k == 0) t = {bcd(20), bcd(99), bcd(12), bcd(31), bcd(23), bcd(59), bcd(59)};
      if (k == 1) t = {bcd(20), bcd(0), bcd(1), bcd(1), bcd(0), bcd(0), bcd(0)};
      stall = 2'(rnd(4));
      run_sec(c, t, k == 5);
      $display("test %0d done", k);
    end
    summarize();
  end
  // watchdog well past twelve seconds of 301 cycles each
  initial begin
    #200000;
    bad_count++;
    summarize();
  end
endmodule // tb
`default_nettype wire
